// ### core/tdmts_edge.sv
// Per-lane edge detector for sampled outside clocks and strobes.
// Assumes inputs are already synchronous to clk.
`timescale 1ns/1ps
module tdmts_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_q[i] <= 1'b0;
        end else begin
          prev_q[i] <= sig[i];
        end
      end
      assign rise[i] = sig[i] & ~prev_q[i];
      assign fall[i] = ~sig[i] & prev_q[i];
    end
  endgenerate

endmodule

// ### core/tdmts_pkg.sv
// Package for the TDM port timing and mode select block.
// Assumes a single 20 MHz system clock; every outside clock is sampled on it.
package tdmts_pkg;

  // System clock
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SYS_CLK_KHZ = SYS_CLK_HZ / 1000;

  // Frame timing
  localparam int FRAME_US = 125;
  localparam int FRAME_HZ = 8000;

  // Serial reference rates
  localparam int SER_4M_KHZ = 4096;
  localparam int SER_8M_KHZ = 8192;
  localparam int SER_CLKS_4M = SER_4M_KHZ * FRAME_US / 1000;
  localparam int SER_CLKS_8M = SER_8M_KHZ * FRAME_US / 1000;
  localparam int SER_CNT_W = 10;
  localparam logic [SER_CNT_W-1:0] SER_LAST_4M = SER_CNT_W'(SER_CLKS_4M - 1);
  localparam logic [SER_CNT_W-1:0] SER_LAST_8M = SER_CNT_W'(SER_CLKS_8M - 1);

  // Internal reference: phase accumulator toggling at twice the clock rate
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] ACC_INC_4M = ACC_W'(2 * SER_4M_KHZ * 65536 / SYS_CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_INC_8M = ACC_W'(2 * SER_8M_KHZ * 65536 / SYS_CLK_KHZ);

  // Serial frame polarity detection
  localparam int RUN_W = 6;
  localparam logic [RUN_W-1:0] RUN_MIN = 6'h10;
  localparam logic [RUN_W-1:0] RUN_MAX = 6'h3F;

  // Parallel rates, bytes per 125 us frame
  localparam int PAR_1944_KHZ = 19440;
  localparam int PAR_16384_KHZ = 16384;
  localparam int PAR_648_KHZ = 6480;
  localparam int PAR_CNT_W = 12;
  localparam logic [PAR_CNT_W-1:0] PAR_LAST_1944 = PAR_CNT_W'(PAR_1944_KHZ * FRAME_US / 1000 - 1);
  localparam logic [PAR_CNT_W-1:0] PAR_LAST_16384 =
    PAR_CNT_W'(PAR_16384_KHZ * FRAME_US / 1000 - 1);
  localparam logic [PAR_CNT_W-1:0] PAR_LAST_648 = PAR_CNT_W'(PAR_648_KHZ * FRAME_US / 1000 - 1);

  // Edge detector lane positions
  localparam int EDGE_N = 5;
  localparam int E_REF_A = 0;
  localparam int E_REF_B = 1;
  localparam int E_RXCLK = 2;
  localparam int E_TXCLK = 3;
  localparam int E_SFP = 4;

  typedef enum logic [1:0] {
    TDMTS_MODE_ONE = 2'h0,
    TDMTS_MODE_TWO = 2'h1,
    TDMTS_MODE_THREE = 2'h3,
    TDMTS_MODE_FOUR = 2'h2
  } tdmts_mode_e;

  typedef enum logic [1:0] {
    TDMTS_PRATE_1944 = 2'h0,
    TDMTS_PRATE_16384 = 2'h1,
    TDMTS_PRATE_648 = 2'h3,
    TDMTS_PRATE_RSVD = 2'h2
  } tdmts_prate_e;

  typedef struct packed {
    tdmts_mode_e mode;
    logic reference_select_bit;
    logic internal_clock_select;
    logic ref_is_8m;
    logic serial_frame_direction_bit;
    logic serial_frame_polarity_bit;
    logic parallel_frame_direction_bit;
    tdmts_prate_e prate;
  } tdmts_cfg_s;

  typedef struct packed {
    tdmts_cfg_s cfg;
    logic [ACC_W-1:0] int_acc;
    logic int_lvl;
    logic sck;
    logic sck_oe_n;
    logic shift_en;
    logic ser_start;
    logic [SER_CNT_W-1:0] ser_cnt;
    logic sfp_out;
    logic sfp_oe_n;
    logic [RUN_W-1:0] run_cnt;
    logic idle_lvl;
    logic fmt_gci;
    logic [7:0] ptx_data;
    logic [3:0] ctrl;
    logic ptx_frame_out;
    logic ptx_frame_oe_n;
    logic [PAR_CNT_W-1:0] tx_cnt;
    logic tx_take;
    logic tx_frame_start;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_frame_start;
  } tdmts_state_s;

endpackage

// ### core/tdmts_top.sv
// Serial and parallel port clock and frame timing selection.
// Assumes outside clocks arrive as plain inputs well below half of ref_clk.
// Behaviour
// - Reference select high takes reference A, low takes reference B.
// - Unselected reference ignored; both ignored when internal clock selected.
// - Mode one or 8.192 MHz: shift serial data on the selected reference.
// - Mode two at 4.096 MHz: retime reference, derive serial clock and frame.
// - Modes three and four never use either serial reference input.
// - Serial frame pulse marks every 125 us frame boundary at 8 kHz.
// - Mode one: frame pulse is input, polarity detected, format adapted.
// - Mode two, direction bit one: frame input with polarity bit format.
// - Mode two direction zero, mode three: drive frame, aligned, set polarity.
// - Mode four leaves the serial frame pulse pin unused.
// - Four control outputs follow the current entry, updated per parallel byte.
// - Transmit bytes leave on the eight-bit parallel output port.
// - Transmit frame driven, input when direction bit high, unused in mode three.
// - Receive data and receive frame are sampled on the receive parallel clock.
// - Modes two to four clock both parallel ports from the receive clock.
// - Mode one clocks transmit side on the transmit clock, otherwise ignored.
// - Receive frame pulse starts each new frame on the receive port.
// - Mode three: receive frame is frame reference for both parallel ports.
// - Modes two and three drive the serial clock, 4.096 or 8.192 MHz; one and four float it.
`timescale 1ns/1ps
module tdmts_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tdmts_pkg::tdmts_cfg_s cfg_in,
  input wire logic serial_clock_ref_a,
  input wire logic serial_clock_ref_b,
  input wire logic serial_frame_pulse_in,
  output logic serial_frame_pulse_out,
  output logic serial_frame_pulse_oe_n,
  output logic serial_clock_output,
  output logic serial_clock_output_oe_n,
  output logic serial_shift_en,
  output logic serial_frame_start,
  output logic serial_format_gci,
  input wire logic parallel_rx_clock,
  input wire logic parallel_tx_clock,
  input wire logic [7:0] parallel_rx_data,
  input wire logic parallel_rx_frame,
  input wire logic parallel_tx_frame_in,
  output logic parallel_tx_frame_out,
  output logic parallel_tx_frame_oe_n,
  output logic [7:0] parallel_tx_data,
  output logic [3:0] external_control_outputs,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] control_line_bits,
  output logic tx_take,
  output logic tx_frame_start,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_frame_start
);

  tdmts_pkg::tdmts_state_s q;
  tdmts_pkg::tdmts_state_s d;
  logic [tdmts_pkg::EDGE_N-1:0] e_rise;
  logic [tdmts_pkg::EDGE_N-1:0] e_fall;

  // Lanes: ref A, ref B, rx clock, tx clock, serial frame pin
  tdmts_edge #(
    .W(tdmts_pkg::EDGE_N)
  ) u_edge (
    .clk(ref_clk),
    .rst(rst),
    .sig({serial_frame_pulse_in, parallel_tx_clock, parallel_rx_clock,
          serial_clock_ref_b, serial_clock_ref_a}),
    .rise(e_rise),
    .fall(e_fall)
  );

  always_comb begin
    logic [tdmts_pkg::ACC_W:0] acc_sum;
    logic [tdmts_pkg::ACC_W-1:0] acc_inc;
    tdmts_pkg::tdmts_mode_e mode;
    logic ext_ok;
    logic src_rise;
    logic src_lvl;
    logic [tdmts_pkg::SER_CNT_W-1:0] ser_last;
    logic [tdmts_pkg::SER_CNT_W-1:0] ser_next;
    logic sfp_drive;
    logic sfp_recv;
    logic act_hi;
    logic sfp_chg;
    logic in_start;
    logic rx_en;
    logic tx_en;
    logic tx_ref;
    logic [tdmts_pkg::PAR_CNT_W-1:0] par_last;
    logic [tdmts_pkg::PAR_CNT_W-1:0] tx_next;
    acc_sum = '0;
    acc_inc = '0;
    mode = q.cfg.mode;
    ext_ok = 1'b0;
    src_rise = 1'b0;
    src_lvl = 1'b0;
    ser_last = '0;
    ser_next = '0;
    sfp_drive = 1'b0;
    sfp_recv = 1'b0;
    act_hi = 1'b0;
    sfp_chg = 1'b0;
    in_start = 1'b0;
    rx_en = 1'b0;
    tx_en = 1'b0;
    tx_ref = 1'b0;
    par_last = '0;
    tx_next = '0;
    d = q;

    // Configuration taken each cycle; routing uses the registered copy
    d.cfg = cfg_in;

    // Internal reference; fractional accumulator gives a jittery mean rate, slightly low from the truncated increment
    acc_inc = q.cfg.ref_is_8m ? tdmts_pkg::ACC_INC_8M : tdmts_pkg::ACC_INC_4M;
    acc_sum = {1'b0, q.int_acc} + {1'b0, acc_inc};
    d.int_acc = acc_sum[tdmts_pkg::ACC_W-1:0];
    if (acc_sum[tdmts_pkg::ACC_W]) begin
      d.int_lvl = ~q.int_lvl;
    end

    // Outside references only in modes one and two without internal clock
    ext_ok = ~q.cfg.internal_clock_select &&
             (mode == tdmts_pkg::TDMTS_MODE_ONE || mode == tdmts_pkg::TDMTS_MODE_TWO);
    if (ext_ok) begin
      if (q.cfg.reference_select_bit) begin
        src_rise = e_rise[tdmts_pkg::E_REF_A];
        src_lvl = serial_clock_ref_a;
      end else begin
        src_rise = e_rise[tdmts_pkg::E_REF_B];
        src_lvl = serial_clock_ref_b;
      end
    end else begin
      src_rise = acc_sum[tdmts_pkg::ACC_W] & ~q.int_lvl;
      src_lvl = d.int_lvl;
    end

    // Serial shifting on the chosen reference; retimed clock in mode two
    d.shift_en = src_rise;
    d.sck = src_lvl;
    d.sck_oe_n = ~(mode == tdmts_pkg::TDMTS_MODE_TWO ||
                   mode == tdmts_pkg::TDMTS_MODE_THREE);
    if (d.sck_oe_n) begin
      d.sck = 1'b0;
    end

    // Serial frame direction and expected polarity
    sfp_drive = (mode == tdmts_pkg::TDMTS_MODE_TWO && ~q.cfg.serial_frame_direction_bit) ||
                mode == tdmts_pkg::TDMTS_MODE_THREE;
    sfp_recv = mode == tdmts_pkg::TDMTS_MODE_ONE ||
               (mode == tdmts_pkg::TDMTS_MODE_TWO && q.cfg.serial_frame_direction_bit);
    act_hi = (mode == tdmts_pkg::TDMTS_MODE_ONE) ? ~q.idle_lvl
                                                 : q.cfg.serial_frame_polarity_bit;
    d.fmt_gci = act_hi;

    // Polarity sense: the level that lasts long is the idle level
    sfp_chg = e_rise[tdmts_pkg::E_SFP] | e_fall[tdmts_pkg::E_SFP];
    if (sfp_chg) begin
      if (mode == tdmts_pkg::TDMTS_MODE_ONE && q.run_cnt >= tdmts_pkg::RUN_MIN) begin
        d.idle_lvl = ~serial_frame_pulse_in;
      end
      d.run_cnt = '0;
    end else if (src_rise && q.run_cnt != tdmts_pkg::RUN_MAX) begin
      d.run_cnt = q.run_cnt + 6'h01;
    end
    in_start = sfp_recv && (act_hi ? e_rise[tdmts_pkg::E_SFP]
                                   : e_fall[tdmts_pkg::E_SFP]);

    // Frame counter: one 125 us frame of serial clocks
    ser_last = q.cfg.ref_is_8m ? tdmts_pkg::SER_LAST_8M : tdmts_pkg::SER_LAST_4M;
    ser_next = (q.ser_cnt >= ser_last) ? '0 : q.ser_cnt + 10'h001;
    d.ser_start = 1'b0;
    if (in_start) begin
      d.ser_cnt = '0;
      d.ser_start = 1'b1;
    end else if (src_rise) begin
      d.ser_cnt = ser_next;
      d.ser_start = sfp_drive && ser_next == '0;
    end

    // Driven pulse spans the last serial clock of each frame
    if (sfp_drive) begin
      d.sfp_oe_n = 1'b0;
      if (src_rise) begin
        d.sfp_out = (ser_next == ser_last) ? q.cfg.serial_frame_polarity_bit
                                           : ~q.cfg.serial_frame_polarity_bit;
      end
    end else begin
      d.sfp_oe_n = 1'b1;
      d.sfp_out = 1'b0;
    end

    // Parallel clock enables; data sampled on the first ref_clk edge that sees the clock high
    rx_en = e_rise[tdmts_pkg::E_RXCLK];
    tx_en = (mode == tdmts_pkg::TDMTS_MODE_ONE) ? e_rise[tdmts_pkg::E_TXCLK]
                                                : rx_en;

    // Receive side
    d.rx_valid = 1'b0;
    d.rx_frame_start = 1'b0;
    if (rx_en) begin
      d.rx_byte = parallel_rx_data;
      d.rx_valid = 1'b1;
      d.rx_frame_start = parallel_rx_frame;
    end

    // Transmit frame reference
    unique case (q.cfg.prate)
      tdmts_pkg::TDMTS_PRATE_1944: par_last = tdmts_pkg::PAR_LAST_1944;
      tdmts_pkg::TDMTS_PRATE_16384: par_last = tdmts_pkg::PAR_LAST_16384;
      tdmts_pkg::TDMTS_PRATE_648: par_last = tdmts_pkg::PAR_LAST_648;
      default: par_last = tdmts_pkg::PAR_LAST_1944;
    endcase
    if (mode == tdmts_pkg::TDMTS_MODE_THREE) begin
      tx_ref = parallel_rx_frame;
    end else if (q.cfg.parallel_frame_direction_bit) begin
      tx_ref = parallel_tx_frame_in;
    end else begin
      tx_ref = 1'b0;
    end
    if (tx_ref || q.tx_cnt >= par_last) begin
      tx_next = '0;
    end else begin
      tx_next = q.tx_cnt + 12'h001;
    end
    d.ptx_frame_oe_n = (mode == tdmts_pkg::TDMTS_MODE_THREE) ||
                       q.cfg.parallel_frame_direction_bit;

    // Transmit side
    d.tx_take = 1'b0;
    d.tx_frame_start = 1'b0;
    if (tx_en) begin
      d.ptx_data = tx_byte;
      d.ctrl = control_line_bits;
      d.tx_take = 1'b1;
      d.tx_cnt = tx_next;
      d.tx_frame_start = tx_next == '0;
      d.ptx_frame_out = ~d.ptx_frame_oe_n && tx_next == '0;
    end
    if (d.ptx_frame_oe_n) begin
      d.ptx_frame_out = 1'b0;
    end

    // Reset state; pins float until configured
    if (rst) begin
      d = '0;
      d.sck_oe_n = 1'b1;
      d.sfp_oe_n = 1'b1;
      d.ptx_frame_oe_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  assign serial_frame_pulse_out = q.sfp_out;
  assign serial_frame_pulse_oe_n = q.sfp_oe_n;
  assign serial_clock_output = q.sck;
  assign serial_clock_output_oe_n = q.sck_oe_n;
  assign serial_shift_en = q.shift_en;
  assign serial_frame_start = q.ser_start;
  assign serial_format_gci = q.fmt_gci;
  assign parallel_tx_frame_out = q.ptx_frame_out;
  assign parallel_tx_frame_oe_n = q.ptx_frame_oe_n;
  assign parallel_tx_data = q.ptx_data;
  assign external_control_outputs = q.ctrl;
  assign tx_take = q.tx_take;
  assign tx_frame_start = q.tx_frame_start;
  assign rx_byte = q.rx_byte;
  assign rx_valid = q.rx_valid;
  assign rx_frame_start = q.rx_frame_start;

endmodule

// ### tb/tdmts_far_model.sv
// Far side: serial references and a slow parallel framer.
// Assumes the block's ref_clk; lines move 1 ns after its rising edge.
`timescale 1ns/1ps
module tdmts_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rx_run,
  input wire logic tx_run,
  output logic serial_clock_ref_a = 1'b0,
  output logic serial_clock_ref_b = 1'b0,
  output logic parallel_rx_clock = 1'b0,
  output logic parallel_tx_clock = 1'b0,
  output logic [7:0] parallel_rx_data = 8'h00,
  output logic parallel_rx_frame = 1'b0
);
  // Rates scaled down, 20 MHz sampling cannot see 19.44 MHz edges
  int ca = 0;
  int cb = 0;
  int cr = 0;
  int ct = 0;
  logic [7:0] cnt = 8'h00;
  always @(posedge ref_clk) begin
    #1;
    ca = (ca + 1) % 5;
    cb = (cb + 1) % 3;
    cr = (cr + 1) % 2;
    ct = (ct + 1) % 3;
    serial_clock_ref_a = ca < 2;
    serial_clock_ref_b = cb < 1;
    if (rst) begin
      parallel_rx_clock = 1'b0;
    end else if (cr == 0 && rx_run) begin
      parallel_rx_clock = !parallel_rx_clock;
      if (parallel_rx_clock) begin
        cnt = cnt + 8'h01;
        parallel_rx_data = cnt;
        parallel_rx_frame = cnt[3:0] == 4'h0;
      end else begin
        // Not valid while clock low
        parallel_rx_data = ~cnt;
        parallel_rx_frame = 1'b0;
      end
    end
    if (rst) begin
      parallel_tx_clock = 1'b0;
    end else if (ct == 0 && tx_run) begin
      parallel_tx_clock = !parallel_tx_clock;
    end
  end
endmodule

// ### tb/tdmts_props.sv
// Port checks for the timing select block.
// Assumes bind onto tdmts_top, one ref_clk domain.
`timescale 1ns/1ps
module tdmts_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire tdmts_pkg::tdmts_cfg_s cfg_in,
  input wire logic serial_clock_ref_a,
  input wire logic serial_clock_ref_b,
  input wire logic serial_clock_output,
  input wire logic serial_clock_output_oe_n,
  input wire logic serial_shift_en,
  input wire logic serial_frame_pulse_out,
  input wire logic serial_frame_pulse_oe_n,
  input wire logic serial_frame_start,
  input wire logic parallel_rx_clock,
  input wire logic parallel_tx_clock,
  input wire logic [7:0] parallel_rx_data,
  input wire logic parallel_rx_frame,
  input wire logic parallel_tx_frame_oe_n,
  input wire logic [7:0] parallel_tx_data,
  input wire logic [3:0] external_control_outputs,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] control_line_bits,
  input wire logic tx_take,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_frame_start
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire m1 = cfg_in.mode == tdmts_pkg::TDMTS_MODE_ONE;
  wire m2 = cfg_in.mode == tdmts_pkg::TDMTS_MODE_TWO;
  wire m3 = cfg_in.mode == tdmts_pkg::TDMTS_MODE_THREE;
  wire m4 = cfg_in.mode == tdmts_pkg::TDMTS_MODE_FOUR;
  wire ext = (m1 || m2) && !cfg_in.internal_clock_select;
  wire sref = cfg_in.reference_select_bit ? serial_clock_ref_a : serial_clock_ref_b;
  // Config steady a cycle, so its register lag has passed
  sequence s_st(c);
    !$past(rst) && $stable(cfg_in) && c;
  endsequence
  AST_REF_SEL: assert property (s_st(ext) |=>
    serial_shift_en == ($past(sref) && !$past(sref, 2)))
    else $error("shift enable not on selected reference");
  AST_SCK_FOLLOW: assert property (s_st(m2 && !cfg_in.internal_clock_select) |=>
    !serial_clock_output_oe_n && serial_clock_output == $past(sref))
    else $error("serial clock does not follow reference");
  AST_SCK_FLOAT: assert property (s_st(m1 || m4) |=>
    serial_clock_output_oe_n && !serial_clock_output)
    else $error("serial clock not floated");
  AST_SER_DRIVE: assert property (s_st(m3) |=>
    !serial_clock_output_oe_n && !serial_frame_pulse_oe_n)
    else $error("serial clock or frame not driven");
  AST_SFP_IN: assert property (
    s_st(m1 || m4 || m2 && cfg_in.serial_frame_direction_bit) |=>
    serial_frame_pulse_oe_n && !serial_frame_pulse_out)
    else $error("serial frame pin driven while input");
  AST_TX_ONE: assert property (s_st(m1 && $rose(parallel_tx_clock)) |=>
    tx_take && parallel_tx_data == $past(tx_byte)
    && external_control_outputs == $past(control_line_bits))
    else $error("transmit byte not taken on tx clock");
  AST_TX_RX: assert property (s_st(!m1 && $rose(parallel_rx_clock)) |=>
    tx_take && parallel_tx_data == $past(tx_byte))
    else $error("transmit byte not taken on rx clock");
  AST_TX_IGN: assert property (s_st(!m1 && !$rose(parallel_rx_clock)) |=>
    !tx_take)
    else $error("transmit taken without rx clock edge");
  AST_RX: assert property ($rose(parallel_rx_clock) |=>
    rx_valid && rx_byte == $past(parallel_rx_data)
    && rx_frame_start == $past(parallel_rx_frame))
    else $error("receive byte or frame wrong");
  AST_TXF_IN: assert property (s_st(cfg_in.parallel_frame_direction_bit) |=>
    parallel_tx_frame_oe_n)
    else $error("tx frame pin driven while input");
  cover property (serial_frame_start);
  cover property (tx_take && m3);
  cover property (rx_valid && rx_frame_start);
endmodule
bind tdmts_top tdmts_props tdmts_props_i (.ref_clk, .rst, .cfg_in, .serial_clock_ref_a,
  .serial_clock_ref_b, .serial_clock_output, .serial_clock_output_oe_n, .serial_shift_en,
  .serial_frame_pulse_out, .serial_frame_pulse_oe_n, .serial_frame_start, .parallel_rx_clock,
  .parallel_tx_clock, .parallel_rx_data, .parallel_rx_frame, .parallel_tx_frame_oe_n,
  .parallel_tx_data, .external_control_outputs, .tx_byte, .control_line_bits, .tx_take,
  .rx_byte, .rx_valid, .rx_frame_start);

// ### tb/tdmts_top_tb.sv
// Self-checking bench for the timing select block.
// Assumes the far model drives all outside clocks.
`timescale 1ns/1ps
module tdmts_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  tdmts_pkg::tdmts_cfg_s cfg_in;
  logic serial_clock_ref_a, serial_clock_ref_b, serial_frame_pulse_in, serial_frame_pulse_out;
  logic serial_frame_pulse_oe_n, serial_clock_output, serial_clock_output_oe_n;
  logic serial_shift_en, serial_frame_start, serial_format_gci, rx_run, tx_run;
  logic parallel_rx_clock, parallel_tx_clock, parallel_rx_frame, parallel_tx_frame_in;
  logic parallel_tx_frame_out, parallel_tx_frame_oe_n, tx_take, tx_frame_start;
  logic rx_valid, rx_frame_start;
  logic [7:0] parallel_rx_data, parallel_tx_data, tx_byte, rx_byte;
  logic [3:0] external_control_outputs, control_line_bits;
  int err_total = 0;
  int check_count = 0;
  always #25 ref_clk = ~ref_clk;
  tdmts_top tdmts_top_i (.ref_clk, .rst, .cfg_in, .serial_clock_ref_a, .serial_clock_ref_b,
    .serial_frame_pulse_in, .serial_frame_pulse_out, .serial_frame_pulse_oe_n,
    .serial_clock_output, .serial_clock_output_oe_n, .serial_shift_en, .serial_frame_start,
    .serial_format_gci, .parallel_rx_clock, .parallel_tx_clock, .parallel_rx_data,
    .parallel_rx_frame, .parallel_tx_frame_in, .parallel_tx_frame_out, .parallel_tx_frame_oe_n,
    .parallel_tx_data, .external_control_outputs, .tx_byte, .control_line_bits, .tx_take,
    .tx_frame_start, .rx_byte, .rx_valid, .rx_frame_start);
  tdmts_far_model tdmts_far_model_i (.ref_clk, .rst, .rx_run, .tx_run, .serial_clock_ref_a,
    .serial_clock_ref_b, .parallel_rx_clock, .parallel_tx_clock, .parallel_rx_data,
    .parallel_rx_frame);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Bits: select, internal, 8m, frame dir, frame pol, parallel dir
  task automatic set_cfg(input tdmts_pkg::tdmts_mode_e m, input logic [5:0] b);
    cfg_in = '{m, b[5], b[4], b[3], b[2], b[1], b[0], tdmts_pkg::TDMTS_PRATE_1944};
    tick(3);
  endtask
  task automatic t_reset();
    rst = 1'b1;
    tick(20);
    check({serial_clock_output_oe_n, serial_frame_pulse_oe_n, parallel_tx_frame_oe_n}, 3'h7);
    check({tx_take, rx_valid, serial_shift_en, parallel_tx_data}, 11'h000);
    rst = 1'b0;
    tick(2);
  endtask
  task automatic t_par_three();
    logic [7:0] e;
    int n;
    set_cfg(tdmts_pkg::TDMTS_MODE_THREE, 6'h00);
    rx_run = 1'b1;
    for (e = 8'h01; e < 8'h29; e++) begin
      tx_byte = ~e;
      control_line_bits = e[3:0];
      n = 0;
      tick(1);
      while (rx_valid !== 1'b1 && n < 50) begin
        tick(1);
        n++;
      end
      check({rx_byte, rx_frame_start}, {e, e[3:0] == 4'h0});
      // First byte after reset included: counter starts from its reset value of zero
      check({tx_take, tx_frame_start}, {1'b1, e[3:0] == 4'h0});
      check({parallel_tx_frame_oe_n, parallel_tx_frame_out}, 2'h2);
      check({parallel_tx_data, external_control_outputs}, {~e, e[3:0]});
    end
    rx_run = 1'b0;
  endtask
  task automatic count_takes(output int n);
    n = 0;
    repeat (60) begin
      tick(1);
      n += (tx_take === 1'b1);
    end
  endtask
  task automatic t_tx_clock();
    int n;
    set_cfg(tdmts_pkg::TDMTS_MODE_ONE, 6'h00);
    tx_run = 1'b1;
    count_takes(n);
    check(n > 8 && n < 12, 1'b1);
    set_cfg(tdmts_pkg::TDMTS_MODE_TWO, 6'h05);
    count_takes(n);
    check(n, 0);
    check(parallel_tx_frame_oe_n, 1'b1);
    tx_run = 1'b0;
  endtask
  task automatic t_serial_ref();
    logic a;
    for (int s = 0; s < 2; s++) begin
      set_cfg(tdmts_pkg::TDMTS_MODE_TWO, {s[0], 5'h00});
      repeat (30) begin
        a = s ? serial_clock_ref_a : serial_clock_ref_b;
        tick(1);
        check({serial_clock_output_oe_n, serial_clock_output}, {1'b0, a});
      end
    end
    set_cfg(tdmts_pkg::TDMTS_MODE_FOUR, 6'h00);
    check({serial_clock_output_oe_n, serial_frame_pulse_oe_n}, 2'h3);
    set_cfg(tdmts_pkg::TDMTS_MODE_ONE, 6'h00);
    check({serial_clock_output_oe_n, serial_frame_pulse_oe_n}, 2'h3);
  endtask
  task automatic t_ser_in();
    // Mode two, frame pin input, active high by the polarity bit
    set_cfg(tdmts_pkg::TDMTS_MODE_TWO, 6'h06);
    serial_frame_pulse_in = 1'b1;
    tick(1);
    check({serial_frame_start, serial_format_gci, serial_frame_pulse_oe_n}, 3'h7);
    tick(1);
    check(serial_frame_start, 1'b0);
    serial_frame_pulse_in = 1'b0;
    // Mode one: a long high level is learnt as idle, so frames go active low
    set_cfg(tdmts_pkg::TDMTS_MODE_ONE, 6'h00);
    serial_frame_pulse_in = 1'b1;
    tick(80);
    serial_frame_pulse_in = 1'b0;
    tick(3);
    check({serial_format_gci, serial_frame_pulse_oe_n}, 2'h1);
    serial_frame_pulse_in = 1'b1;
    tick(2);
    serial_frame_pulse_in = 1'b0;
    tick(1);
    check(serial_frame_start, 1'b1);
    tick(1);
    check(serial_frame_start, 1'b0);
  endtask
  task automatic t_frame(input logic m8, input logic pol, input int len);
    int n;
    int k;
    logic last;
    set_cfg(tdmts_pkg::TDMTS_MODE_THREE, {2'b00, m8, 1'b0, pol, 1'b0});
    k = 0;
    n = 0;
    while (serial_frame_start !== 1'b1 && k < 6000) begin
      tick(1);
      k++;
    end
    do begin
      last = serial_frame_pulse_out;
      tick(1);
      n += (serial_shift_en === 1'b1);
      k++;
    end while (serial_frame_start !== 1'b1 && k < 12000);
    check(n, len);
    check({serial_frame_pulse_oe_n, last, serial_frame_pulse_out}, {1'b0, pol, !pol});
  endtask
  initial begin
    #2_000_000;
    err_total++;
    wrap_up();
  end
  initial begin
    cfg_in = '0;
    {serial_frame_pulse_in, parallel_tx_frame_in, rx_run, tx_run} = 4'h0;
    tx_byte = 8'h00;
    control_line_bits = 4'h0;
    t_reset();
    t_par_three();
    t_tx_clock();
    t_serial_ref();
    t_ser_in();
    t_reset();
    t_frame(1'b0, 1'b1, 512);
    t_frame(1'b1, 1'b0, 1024);
    wrap_up();
  end
endmodule
